// file: core/gltc_core.sv
// Teach-in, lock decoding, safety output gating and LED indication of the guard lock
//
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// How it works
// - Standard coding works without any teach-in
// - Teach: green off, red on, yellow 1 Hz
// - After ten seconds yellow blinks short at 3 Hz
// - No power-off in five minutes: abort, five flashes
// - Taught code activates on detection after power-up
// - Single-teach variant never replaces a stored pairing
// - Repeat-teach variant teaches without limit
// - New code invalidates the old actuator
// - Repeat variant holds ten minute enabling inhibit
// - Green blinks until inhibit ends and actuator seen
// - Power loss restarts the inhibit from zero
// - Handle between detents refuses locking
// - Energise-to-release: high unlocks, low locks
// - Energise-to-lock: high locks, low releases
// - Unlock-sensitive variant drops outputs on unlock
// - Relock with actuator inserted restores outputs
// - Open-sensitive variant drops outputs only on opening
// - Green supply, yellow state, red fault
// - Chain input missing: green 1 Hz, red off
module gltc_core import gltc_pkg::*; #(
  parameter int CYC = CYC_BASE // Clock cycles per base tick
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Power-up reset, active low
  input wire logic [ADDR_W-1:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic actuator_present, // Actuator in detection range
  input wire logic [CODE_W-1:0] actuator_code, // Code read from actuator
  input wire logic handle_mid, // Handle between its two detents
  input wire logic lock_cmd, // Lock command line
  input wire logic chain_enable_a, // Chain input, channel A
  input wire logic chain_enable_b, // Chain input, channel B
  input wire gltc_nv_t nv_rdata, // Retained pairing store content
  output logic nv_we, // Store write pulse
  output gltc_nv_t nv_wdata, // Store write data
  output logic solenoid_lock, // Solenoid holds the guard locked
  output logic safety_channel_a_drive, // Safety output A
  output logic safety_channel_b_drive, // Safety output B
  output gltc_led_t led // Three-colour indicator
);
  // ==========================================================
  // Timing base
  logic base_tick; // Base rate pulse
  logic [PH_W-1:0] phase; // Phase within the second
  logic sec_tick; // Seconds pulse

  gltc_ticker #(.CYC(CYC)) u_ticker (
    .pclk(pclk),
    .presetn(presetn),
    .base_tick(base_tick),
    .phase(phase),
    .sec_tick(sec_tick)
  );

  // ==========================================================
  // State declarations
  gltc_state_t state_ff, nxt_state; // Teach and inhibit sequencer
  logic [SEC_W-1:0] sec_ff, nxt_sec; // Seconds in current state
  gltc_nv_t nv_ff, nxt_nv; // Shadow of the retained store
  logic nv_we_ff, nxt_nv_we; // Store write strobe
  logic done_ff, nxt_done; // Inhibit time has run out
  gltc_ctrl_t ctrl_ff, nxt_ctrl; // Control register
  logic [31:0] prdata_ff, nxt_prdata; // Read data
  logic pready_ff, nxt_pready; // Ready, one wait state
  logic pslverr_ff, nxt_pslverr; // Error flag
  logic lock_ff, nxt_lock; // Solenoid state
  logic safe_ff, nxt_safe; // Safety output enable
  gltc_led_t led_ff, nxt_led; // Indicator state
  logic [3:0] red_ff, nxt_red; // Red flash code step

  // ==========================================================
  // Shared decodes
  logic code_match; // Actuator carries the active code
  logic accepted; // Actuator counts as a closed guard
  logic chain_ok; // Both chain inputs present
  logic lock_req; // Decoded lock request
  logic slow; // 1 Hz square wave
  logic fast; // 3 Hz short blinks
  logic red_flash; // Red flash code level
  logic sec_last; // Last second of the current interval

  // Interval length of each timed state
  function automatic logic [SEC_W-1:0] interval(input gltc_state_t s);
    case (s)
      ST_TEACH: interval = SEC_W'(TEACH_S);
      ST_WAIT_OFF: interval = SEC_W'(ABORT_S);
      default: interval = SEC_W'(INHIBIT_S);
    endcase
  endfunction : interval

  always_comb begin
    code_match = nv_ff.valid && (actuator_code == nv_ff.code);
    accepted = actuator_present && (!ctrl_ff.indiv_coded || code_match);
    chain_ok = chain_enable_a && chain_enable_b;
    lock_req = ctrl_ff.power_to_lock ? lock_cmd : !lock_cmd;
    slow = (int'(phase) < PH_SLOW);
    fast = ((int'(phase) % PH_FAST) < PH_FAST_ON);
    red_flash = (red_ff < RED_ON_STEPS) && !red_ff[0];
    sec_last = sec_tick && (sec_ff == interval(state_ff) - SEC_W'(1));
  end

  // ==========================================================
  // Sequencer: boot, teach, power-off wait, abort and inhibit
  always_comb begin
    nxt_state = state_ff;
    nxt_sec = sec_tick ? sec_ff + SEC_W'(1) : sec_ff;
    nxt_nv = nv_ff;
    nxt_nv_we = 1'b0;
    nxt_done = done_ff;
    case (state_ff)
      ST_BOOT: begin
        // The store is read once after power-up; an owed inhibit restarts
        nxt_nv = nv_rdata;
        nxt_sec = '0;
        nxt_done = 1'b0;
        nxt_state = nv_rdata.inhibit ? ST_INHIBIT : ST_RUN;
      end
      ST_RUN: begin
        nxt_sec = '0;
        if (ctrl_ff.indiv_coded && actuator_present) begin
          if (nv_ff.pending && actuator_code == nv_ff.cand) begin
            // First detection after power returns activates the code
            nxt_nv.code = nv_ff.cand;
            nxt_nv.valid = 1'b1;
            nxt_nv.pending = 1'b0;
            nxt_nv.inhibit = ctrl_ff.repeat_teach_variant;
            nxt_nv_we = 1'b1;
            nxt_done = 1'b0;
            if (ctrl_ff.repeat_teach_variant) begin
              nxt_state = ST_INHIBIT;
            end
          end else if (!code_match && !nv_ff.pending
                       && (ctrl_ff.repeat_teach_variant || !nv_ff.valid)) begin
            // A stored pairing in the single-teach variant is final
            nxt_nv.cand = actuator_code;
            nxt_state = ST_TEACH;
          end
        end
      end
      ST_TEACH: begin
        if (!actuator_present) begin
          // Actuator withdrawn early: nothing was learned
          nxt_state = ST_RUN;
        end else if (sec_last) begin
          nxt_nv.pending = 1'b1;
          nxt_nv_we = 1'b1;
          nxt_sec = '0;
          nxt_state = ST_WAIT_OFF;
        end
      end
      ST_WAIT_OFF: begin
        if (sec_last) begin
          // Power stayed on: drop the taught code and report a fault
          nxt_nv.pending = 1'b0;
          nxt_nv_we = 1'b1;
          nxt_state = ST_ABORT;
        end
      end
      ST_ABORT: begin
        // Left only by a power cycle
        nxt_sec = '0;
      end
      ST_INHIBIT: begin
        if (sec_last) begin
          nxt_done = 1'b1;
        end
        if (done_ff && accepted) begin
          nxt_nv.inhibit = 1'b0;
          nxt_nv_we = 1'b1;
          nxt_state = ST_RUN;
        end
        if (done_ff) begin
          nxt_sec = '0;
        end
      end
      default: nxt_state = ST_BOOT;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_BOOT;
      sec_ff <= '0;
      nv_ff <= '0;
      nv_we_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      sec_ff <= nxt_sec;
      nv_ff <= nxt_nv;
      nv_we_ff <= nxt_nv_we;
      done_ff <= nxt_done;
    end
  end

  // ==========================================================
  // APB slave: one wait state, writes land on the ready edge
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_pready = psel && penable && !pready_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel && penable && pready_ff && pwrite && paddr == ADDR_CTRL) begin
      nxt_ctrl = gltc_ctrl_t'(pwdata[3:0]);
    end
    if (nxt_pready) begin
      case (paddr)
        ADDR_CTRL: nxt_prdata = {28'h0, ctrl_ff};
        ADDR_STATUS: nxt_prdata = {21'h0, led_ff, nv_ff.valid, nv_ff.pending,
                                   nv_ff.inhibit, safe_ff, lock_ff, state_ff};
        default: begin
          // Unmapped: error answer, zero data
          nxt_prdata = 32'h0;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= gltc_ctrl_t'(CTRL_RST);
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ==========================================================
  // Lock, safety outputs and indicator
  always_comb begin
    // Locking needs a closed guard and a handle in a detent
    nxt_lock = lock_req && accepted && !handle_mid;
    // Unlock-sensitive outputs follow the lock; open-sensitive only the guard
    nxt_safe = chain_ok && accepted && (state_ff == ST_RUN)
               && (ctrl_ff.open_sensitive || lock_ff);
    nxt_red = red_ff;
    if (base_tick && (int'(phase) % PH_RED) == 0) begin
      nxt_red = red_ff + 4'h1;
    end
    // Normal view: green supply, yellow guard state, red clear
    nxt_led.green = 1'b1;
    nxt_led.red = 1'b0;
    nxt_led.yellow = !accepted ? 1'b0 : (lock_ff ? 1'b1 : slow);
    if (!chain_ok) begin
      nxt_led.green = slow;
    end
    case (state_ff)
      ST_TEACH: nxt_led = '{green: 1'b0, red: 1'b1, yellow: slow};
      ST_WAIT_OFF: nxt_led = '{green: 1'b0, red: 1'b1, yellow: fast};
      ST_ABORT: nxt_led = '{green: 1'b1, red: red_flash, yellow: 1'b0};
      ST_INHIBIT: nxt_led = '{green: slow, red: 1'b0, yellow: 1'b0};
      default: ;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_ff <= 1'b0;
      safe_ff <= 1'b0;
      led_ff <= '0;
      red_ff <= 4'h0;
    end else begin
      lock_ff <= nxt_lock;
      safe_ff <= nxt_safe;
      led_ff <= nxt_led;
      red_ff <= nxt_red;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign nv_we = nv_we_ff;
  assign nv_wdata = nv_ff;
  assign solenoid_lock = lock_ff;
  assign safety_channel_a_drive = safe_ff;
  assign safety_channel_b_drive = safe_ff;
  assign led = led_ff;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_teach_leds: assert property (state_ff == ST_TEACH |=> !led_ff.green && led_ff.red)
    else $error("teach indication wrong");
  a_teach_timeout: assert property (state_ff == ST_TEACH && actuator_present && sec_last
    |=> state_ff == ST_WAIT_OFF && nv_we_ff && nv_ff.pending)
    else $error("power-off request not raised after ten seconds");
  a_abort_time: assert property (state_ff == ST_WAIT_OFF && sec_last
    |=> state_ff == ST_ABORT && !nv_ff.pending)
    else $error("teach not aborted after five minutes");
  a_single_keep: assert property (!ctrl_ff.repeat_teach_variant && nv_ff.valid
    && state_ff != ST_BOOT |=> $stable(nv_ff.code) || ctrl_ff.repeat_teach_variant)
    else $error("stored pairing replaced in single-teach variant");
  a_inhibit_enter: assert property (nv_we_ff && nv_ff.inhibit |-> state_ff == ST_INHIBIT)
    else $error("inhibit flag without inhibit state");
  a_commit_inh: assert property (state_ff == ST_RUN && nxt_nv_we && nv_ff.pending
    && ctrl_ff.repeat_teach_variant |=> state_ff == ST_INHIBIT ##1 !safe_ff)
    else $error("no inhibit after new actuator");
  a_lock_refuse: assert property (handle_mid |=> !lock_ff)
    else $error("locked with handle between detents");
  a_lock_release: assert property (!ctrl_ff.power_to_lock && lock_cmd
    && $stable(ctrl_ff) |=> !lock_ff)
    else $error("energise-to-release did not unlock");
  a_unlock_drop: assert property (!ctrl_ff.open_sensitive && !lock_ff
    |=> !safety_channel_a_drive && !safety_channel_b_drive)
    else $error("outputs on while unlocked");
  a_outputs_off: assert property (state_ff != ST_RUN |=> !safe_ff)
    else $error("outputs on during teach or inhibit");
  a_chain_led: assert property (!chain_ok && state_ff == ST_RUN
    |=> !led_ff.red && led_ff.green == $past(slow))
    else $error("chain indication wrong");

  c_teach: cover property (state_ff == ST_TEACH ##1 state_ff == ST_WAIT_OFF);
  c_abort: cover property (state_ff == ST_WAIT_OFF ##1 state_ff == ST_ABORT);
  c_inhibit_end: cover property (state_ff == ST_INHIBIT ##1 state_ff == ST_RUN);
  c_locked_safe: cover property (lock_ff && safe_ff);
endmodule : gltc_core

// file: pkg/gltc_pkg.sv
// Shared constants, field layouts and types of the guard lock teach controller
package gltc_pkg;
  // ==========================================================
  // Clock and derived tick rates
  localparam int CLK_HZ = 50_000_000; // System clock rate
  localparam int BASE_HZ = 24; // Base tick rate of the divider
  localparam int CYC_BASE = CLK_HZ / BASE_HZ; // Clock cycles per base tick
  localparam int BLINK_SLOW_HZ = 1; // Status blink rate
  localparam int BLINK_FAST_HZ = 3; // Power-off request blink rate
  localparam int RED_STEP_HZ = 4; // Step rate of the red flash code
  localparam int PH_SLOW = BASE_HZ / (2 * BLINK_SLOW_HZ); // Ticks per half slow period
  localparam int PH_FAST = BASE_HZ / BLINK_FAST_HZ; // Ticks per fast period
  localparam int PH_FAST_ON = 2; // Ticks lit in a short fast blink
  localparam int PH_RED = BASE_HZ / RED_STEP_HZ; // Ticks per red step
  localparam int PH_W = 5; // Width of the base tick phase

  // ==========================================================
  // Intervals, in seconds
  localparam int TEACH_S = 10; // Teach time before power-off request
  localparam int ABORT_MIN = 5; // Wait for power-off, in minutes
  localparam int ABORT_S = ABORT_MIN * 60; // Same wait in seconds
  localparam int INHIBIT_MIN = 10; // Anti-tamper enabling inhibit, minutes
  localparam int INHIBIT_S = INHIBIT_MIN * 60; // Same inhibit in seconds
  localparam int SEC_W = 10; // Width of the seconds counter
  localparam int FAULT_FLASHES = 5; // Red flashes after a teach abort
  localparam logic [3:0] RED_ON_STEPS = 4'hA; // Two steps per flash

  // ==========================================================
  // Register map on APB
  localparam int ADDR_W = 8; // Decoded address width
  localparam logic [7:0] ADDR_CTRL = 8'h00; // Control register
  localparam logic [7:0] ADDR_STATUS = 8'h04; // Status register
  localparam logic [3:0] CTRL_RST = 4'h1; // Individual coding, single teach

  // ==========================================================
  // Types
  localparam int CODE_W = 16; // Actuator code width

  typedef struct packed {
    logic open_sensitive; // 1: outputs drop only on opening
    logic power_to_lock; // 1: high command locks
    logic repeat_teach_variant; // 1: teach may repeat
    logic indiv_coded; // 1: individually coded unit
  } gltc_ctrl_t;

  typedef struct packed {
    logic valid; // Stored code is active
    logic pending; // Taught code awaits confirmation
    logic inhibit; // Enabling inhibit still owed
    logic [CODE_W-1:0] cand; // Code taught, not yet active
    logic [CODE_W-1:0] code; // Active code
  } gltc_nv_t;

  typedef struct packed {
    logic green; // Supply present
    logic red; // Fault
    logic yellow; // Operating state
  } gltc_led_t;

  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_RUN = 3'h1,
    ST_TEACH = 3'h2,
    ST_WAIT_OFF = 3'h3,
    ST_ABORT = 3'h4,
    ST_INHIBIT = 3'h5
  } gltc_state_t;
endpackage : gltc_pkg

// file: core/gltc_ticker.sv
// Free-running divider that makes the base tick, its phase and the seconds tick
`timescale 1ns/1ps
module gltc_ticker import gltc_pkg::*; #(
  parameter int CYC = CYC_BASE // Clock cycles per base tick
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Asynchronous reset, active low
  output logic base_tick, // One-cycle pulse at the base rate
  output logic [PH_W-1:0] phase, // Base ticks within the second
  output logic sec_tick // One-cycle pulse once a second
);
  logic [31:0] cnt_ff; // Cycle counter
  logic [31:0] nxt_cnt;
  logic [PH_W-1:0] ph_ff; // Phase counter
  logic [PH_W-1:0] nxt_ph;
  logic tick_ff; // Registered base tick
  logic nxt_tick;
  logic sec_ff; // Registered seconds tick
  logic nxt_sec;

  // ==========================================================
  // Next values: wrap the cycle count, step the phase on each tick
  always_comb begin
    nxt_tick = (cnt_ff == 32'(CYC - 1));
    nxt_cnt = nxt_tick ? 32'h0 : cnt_ff + 32'h1;
    nxt_ph = ph_ff;
    nxt_sec = 1'b0;
    if (nxt_tick) begin
      nxt_sec = (ph_ff == PH_W'(BASE_HZ - 1));
      nxt_ph = nxt_sec ? '0 : ph_ff + PH_W'(1);
    end
  end

  // Counters clear only at power-up, so an interval begun later, such as a teach, starts part way into a second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 32'h0;
      ph_ff <= '0;
      tick_ff <= 1'b0;
      sec_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      ph_ff <= nxt_ph;
      tick_ff <= nxt_tick;
      sec_ff <= nxt_sec;
    end
  end

  assign base_tick = tick_ff;
  assign phase = ph_ff;
  assign sec_tick = sec_ff;
endmodule : gltc_ticker

// file: verification/gltc_plc_model.sv
// Far-side safety controller model: drives the lock command, reads the safety outputs
`timescale 1ns/1ps
module gltc_plc_model (
  input wire logic pclk, // System clock
  input wire logic presetn, // Reset, active low
  input wire logic want_lock, // Bench asks for the guard locked
  input wire logic power_to_lock, // Polarity version of the lock line
  input wire logic [1:0] lag, // Cycles of delay before the line follows
  input wire logic safety_a, // Safety output A
  input wire logic safety_b, // Safety output B
  output logic lock_cmd, // Lock command line
  output logic run_ok // Both channels enabled
);
  // ==========================================================
  // Lock line drive
  logic [1:0] wait_ff; // Cycles already held on a new request
  logic target; // Line level that means the wanted state
  // High locks in one version, high releases in the other
  assign target = want_lock ~^ power_to_lock;
  // A slow controller follows a request only after lag cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cmd <= 1'b0;
      wait_ff <= 2'h0;
      run_ok <= 1'b0;
    end else begin
      run_ok <= safety_a & safety_b;
      if (target == lock_cmd) begin
        wait_ff <= 2'h0;
      end else if (wait_ff >= lag) begin
        lock_cmd <= target;
        wait_ff <= 2'h0;
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
endmodule : gltc_plc_model

// file: verification/gltc_bench.sv
// Self-checking bench of the guard lock teach controller
`timescale 1ns/1ps
module gltc_bench;
  import gltc_pkg::*;
  // ==========================================================
  // Stimulus and observation signals
  localparam int CYC_T = 4; // Short base tick keeps minutes affordable
  localparam int SEC = CYC_T * BASE_HZ; // Clock cycles per second
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, nv_we, solenoid_lock, saf_a, saf_b, lock_cmd, run_ok;
  logic present = 1'b0, handle_mid = 1'b0, chain_a = 1'b1, chain_b = 1'b1;
  logic want_lock = 1'b0, ptl = 1'b0;
  logic [1:0] lag = 2'h0;
  logic [CODE_W-1:0] act_code = 16'h0000, cur_code = 16'h0000, code_a, code_b;
  gltc_nv_t nv_q = '0, nv_wdata; // Retained store survives every reset
  gltc_led_t led;
  logic [65:0] exp_q[$]; // Read notes: mask over expected
  int seed = 92, err_total = 0, check_count = 0, cyc_now = 0, t0, r, h;
  always #10 pclk = ~pclk;
  // Retained pairing store and free cycle count
  always @(posedge pclk) begin
    cyc_now <= cyc_now + 1;
    if (nv_we === 1'b1) nv_q <= nv_wdata;
    // With no actuator in range the code lines carry noise
    act_code <= present ? cur_code : 16'($random(seed));
  end
  gltc_core #(.CYC(CYC_T)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .actuator_present(present), .actuator_code(act_code),
    .handle_mid(handle_mid), .lock_cmd(lock_cmd), .chain_enable_a(chain_a),
    .chain_enable_b(chain_b), .nv_rdata(nv_q), .nv_we(nv_we), .nv_wdata(nv_wdata),
    .solenoid_lock(solenoid_lock), .safety_channel_a_drive(saf_a),
    .safety_channel_b_drive(saf_b), .led(led));
  gltc_plc_model plc (.pclk(pclk), .presetn(presetn), .want_lock(want_lock),
    .power_to_lock(ptl), .lag(lag), .safety_a(saf_a), .safety_b(saf_b),
    .lock_cmd(lock_cmd), .run_ok(run_ok));
  // ==========================================================
  // Compare tasks and run end
  task automatic chk_pin(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk_pin
  task automatic chk_rd(input logic [32:0] e, input logic [32:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] apb_read expected %0h seen %0h", e, g);
    end
  endtask : chk_rd
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // Read results are judged where the answer appears, oldest note first
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk_rd(exp_q[0][32:0], exp_q[0][65:33] & {pslverr, prdata});
      void'(exp_q.pop_front());
    end
  end
  // ==========================================================
  // Bus, reset and measuring tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] m, input logic [32:0] e);
    @(posedge pclk);
    if (!wr) exp_q.push_back({m, e});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until ready is seen at a rising edge; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic power_cycle();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask : power_cycle
  task automatic wait_nv(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (nv_we !== 1'b1 && n < lim);
  endtask : wait_nv
  // Counts rising edges and lit cycles of one indicator colour
  task automatic meas(input int sel, input int ncyc);
    logic prev;
    @(negedge pclk);
    prev = led[sel];
    r = 0;
    h = 0;
    repeat (ncyc) begin
      @(negedge pclk);
      r += int'(led[sel] && !prev);
      h += int'(led[sel]);
      prev = led[sel];
    end
  endtask : meas
  // Watchdog sized above the ten-minute inhibit plus the teach runs
  initial begin
    repeat (100000) @(posedge pclk);
    err_total++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    code_a = 16'($random(seed));
    code_b = code_a ^ 16'($random(seed) | 1);
    power_cycle();
    apb(1'b0, ADDR_CTRL, 32'h0, {33{1'b1}}, 33'h1);
    apb(1'b0, 8'h08, 32'h0, {33{1'b1}}, {1'b1, 32'h0});
    apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF, 33'h0, 33'h0);
    apb(1'b0, ADDR_STATUS, 32'h0, 33'h7, 33'h1);
    $display("test registers done");
    // Standard coding, both lock polarities and both output variants
    apb(1'b1, ADDR_CTRL, 32'h0, 33'h0, 33'h0);
    lag <= 2'h2;
    present <= 1'b1;
    cur_code <= code_a;
    want_lock <= 1'b1;
    repeat (12) @(posedge pclk);
    chk_pin("lock", 32'h1, 32'(solenoid_lock));
    chk_pin("run_ok", 32'h1, 32'(run_ok));
    chk_pin("led", 32'h5, 32'(led));
    want_lock <= 1'b0;
    repeat (12) @(posedge pclk);
    chk_pin("unlock_safety", 32'h0, 32'({saf_a, saf_b}));
    want_lock <= 1'b1;
    repeat (12) @(posedge pclk);
    chk_pin("relock_safety", 32'h3, 32'({saf_a, saf_b}));
    handle_mid <= 1'b1;
    want_lock <= 1'b0;
    repeat (12) @(posedge pclk);
    want_lock <= 1'b1;
    repeat (12) @(posedge pclk);
    chk_pin("handle_lock", 32'h0, 32'(solenoid_lock));
    handle_mid <= 1'b0;
    chain_b <= 1'b0;
    repeat (12) @(posedge pclk);
    meas(2, 2 * SEC);
    chk_pin("chain_green", 32'h2, r);
    meas(0, SEC);
    chk_pin("chain_yellow_locked", SEC, h);
    want_lock <= 1'b0;
    present <= 1'b0;
    meas(1, SEC);
    chk_pin("chain_red", 32'h0, h);
    meas(0, SEC);
    chk_pin("chain_yellow_open", 32'h0, h);
    chain_b <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h8, 33'h0, 33'h0);
    present <= 1'b1;
    want_lock <= 1'b1;
    repeat (12) @(posedge pclk);
    want_lock <= 1'b0;
    repeat (12) @(posedge pclk);
    chk_pin("open_sens_unlock", 32'h1, 32'(run_ok));
    present <= 1'b0;
    repeat (12) @(posedge pclk);
    chk_pin("open_sens_open", 32'h0, 32'(run_ok));
    apb(1'b1, ADDR_CTRL, 32'h4, 33'h0, 33'h0);
    ptl <= 1'b1;
    present <= 1'b1;
    want_lock <= 1'b1;
    repeat (12) @(posedge pclk);
    chk_pin("ptl_lock", 32'h3, 32'({lock_cmd, solenoid_lock}));
    want_lock <= 1'b0;
    present <= 1'b0;
    ptl <= 1'b0;
    lag <= 2'h0;
    $display("test standard done");
    // Teach-in left to run out: timed indications and abort
    power_cycle();
    present <= 1'b1;
    cur_code <= code_a;
    t0 = cyc_now;
    apb(1'b0, ADDR_STATUS, 32'h0, 33'h7, 33'h2);
    meas(0, 4 * SEC);
    chk_pin("teach_yellow", 32'h4, r);
    chk_pin("teach_gr", 32'h1, 32'({led.green, led.red}));
    chk_pin("teach_safety", 32'h0, 32'({saf_a, saf_b}));
    wait_nv(12 * SEC);
    chk_pin("teach_time", 32'h1, 32'(cyc_now - t0 >= 9 * SEC && cyc_now - t0 <= 10 * SEC + 2));
    chk_pin("cand", {16'h1, code_a}, {15'h0, nv_wdata.pending, nv_wdata.cand});
    t0 = cyc_now;
    meas(0, 4 * SEC);
    chk_pin("fast_yellow", 32'hC, r);
    chk_pin("fast_short", 32'h1, 32'(h < 2 * SEC));
    wait_nv(302 * SEC);
    chk_pin("abort_time", 32'h1, 32'(cyc_now - t0 >= 299 * SEC && cyc_now - t0 <= 300 * SEC + 2));
    chk_pin("abort_pending", 32'h0, 32'(nv_wdata.pending));
    meas(1, 4 * SEC);
    chk_pin("abort_red", 32'h5, r);
    $display("test teach abort done");
    // Single-teach: learn, confirm after power-up, refuse a second code
    present <= 1'b0;
    power_cycle();
    present <= 1'b1;
    wait_nv(12 * SEC);
    power_cycle();
    wait_nv(4 * SEC);
    chk_pin("learn", {16'h2, code_a}, {14'h0, nv_wdata.valid, nv_wdata.inhibit, nv_wdata.code});
    want_lock <= 1'b1;
    repeat (12) @(posedge pclk);
    chk_pin("learned_run", 32'h1, 32'(run_ok));
    cur_code <= code_b;
    t0 = cyc_now;
    wait_nv(2 * SEC);
    chk_pin("no_reteach", 2 * SEC, cyc_now - t0);
    apb(1'b0, ADDR_STATUS, 32'h0, 33'h7, 33'h1);
    $display("test single teach done");
    // Repeat-teach: new code, inhibit, power loss during the inhibit
    power_cycle();
    apb(1'b1, ADDR_CTRL, 32'h3, 33'h0, 33'h0);
    wait_nv(12 * SEC);
    present <= 1'b0;
    power_cycle();
    apb(1'b1, ADDR_CTRL, 32'h3, 33'h0, 33'h0);
    present <= 1'b1;
    wait_nv(4 * SEC);
    chk_pin("relearn", {16'h3, code_b}, {14'h0, nv_wdata.valid, nv_wdata.inhibit, nv_wdata.code});
    meas(2, 2 * SEC);
    chk_pin("inhibit_green", 32'h2, r);
    chk_pin("inhibit_safety", 32'h0, 32'({saf_a, saf_b}));
    power_cycle();
    t0 = cyc_now;
    apb(1'b1, ADDR_CTRL, 32'h3, 33'h0, 33'h0);
    wait_nv(602 * SEC);
    chk_pin("inhibit_time", 32'h1, 32'(cyc_now - t0 >= 599 * SEC && cyc_now - t0 <= 600 * SEC + 4));
    chk_pin("inhibit_clear", 32'h0, 32'(nv_wdata.inhibit));
    repeat (12) @(posedge pclk);
    chk_pin("after_inhibit", 32'h1, 32'(run_ok));
    cur_code <= code_a;
    repeat (12) @(posedge pclk);
    chk_pin("old_code", 32'h0, 32'(run_ok));
    $display("test repeat teach done");
    conclude();
  end
endmodule : gltc_bench
